// file: verilog/sdadc_ctrl.sv
// sigma-delta converter control, decimation and calibration sequencer
module sdadc_ctrl #(
   parameter bit WIDE_RESULT = 1'b1  // 0 gives the 16-bit variant
) (
   input  wire logic        sys_clk,      // 25 MHz system clock
   input  wire logic        rst_n,        // synchronous reset, active low
   input  wire logic [7:0]  paddr,        // apb address
   input  wire logic        psel,         // apb select
   input  wire logic        penable,      // apb enable
   input  wire logic        pwrite,       // apb direction
   input  wire logic [31:0] pwdata,       // apb write data
   output logic      [31:0] prdata,       // apb read data
   output logic             pready,       // apb ready
   output logic             pslverr,      // apb error, unmapped address
   input  wire logic        mod_bit,      // modulator bitstream
   output logic             adc_power_on, // analog section powered
   output logic             ref_ext_sel,  // external reference chosen
   output logic      [2:0]  amp_gain_sel, // gain code, gain is 2**code
   output logic      [1:0]  buf_pos_sel,  // positive input buffer
   output logic      [1:0]  buf_neg_sel,  // negative input buffer
   output logic             in_short_analog_ground,// inputs tied to analog ground
   output logic             in_fullscale, // inputs tied to ref over gain
   output logic             mod_clk_tick, // modulator clock enable
   output logic             conv_irq,     // converter interrupt pulse
   output logic             result_valid, // new main filter word
   output logic             fast_valid    // new fast filter word
);
   // ***************************************************************
   // types and helpers
   // ***************************************************************
   typedef enum logic [2:0] {
      S_IDLE = 3'h1,
      S_MEAS = 3'h2,
      S_DIV  = 3'h4
   } cal_state_t;

   typedef struct packed {
      cal_state_t  st;
      logic        en;
      logic [2:0]  sm;
      logic        ref_ext;
      logic [2:0]  gn;
      logic [3:0]  buff;
      logic [7:0]  mdiv;
      logic [10:0] decim_field;
      logic [23:0] off;
      logic [23:0] gain;
      logic        busy;
      logic        done;
      logic        irq;
      logic        second;
      logic        is_gain;
      logic        is_int;
      logic        short;
      logic        fs;
      logic [23:0] acc;
      logic [23:0] facc;
      logic [10:0] cnt;
      logic [10:0] fcnt;
      logic [23:0] res;
      logic [23:0] fres;
      logic        rvalid;
      logic        fvalid;
      logic [34:0] num;
      logic [35:0] rem;
      logic [34:0] quo;
      logic [24:0] den;
      logic [5:0]  step;
      logic [31:0] prdata;
      logic        pready;
      logic        pslverr;
   } ctrl_state_t;

   // offset subtraction then 1.23 gain multiply
   function automatic logic [23:0] correct(input logic [23:0] raw, input logic [23:0] o,
                                           input logic [23:0] g);
      logic signed [24:0] diff;
      logic signed [24:0] gs;
      logic signed [49:0] prod;
      diff = $signed({raw[23], raw}) - $signed({o[23], o});
      gs   = $signed({1'b0, g});
      prod = diff * gs;
      // narrow variant keeps the upper 16 bits only
      return WIDE_RESULT ? prod[46:23] : {prod[46:31], 8'h00};
   endfunction : correct

   function automatic logic is_cal(input logic [2:0] m);
      return m == sdadc_pkg::SM_INT_FULL || m == sdadc_pkg::SM_INT_OFS || m == sdadc_pkg::SM_INT_GAIN ||
             m == sdadc_pkg::SM_SYS_OFS || m == sdadc_pkg::SM_SYS_GAIN;
   endfunction : is_cal

   ctrl_state_t q;
   ctrl_state_t d;
   cdiv_if      cdiv ();

   modclk_gen u_modclk_gen (
      .sys_clk (sys_clk),
      .rst_n   (rst_n),
      .bus     (cdiv.gen)
   );

   assign cdiv.en  = q.en;
   assign cdiv.div = q.mdiv;

   // ***************************************************************
   // next state
   // ***************************************************************
   always_comb begin
      logic        wr;
      logic        word;
      logic [23:0] delta;
      logic [23:0] sum;
      logic [23:0] fsum;
      logic [10:0] flast;
      logic [35:0] rsh;
      logic        fin;
      wr    = psel && penable && q.pready && pwrite;
      word  = 1'b0;
      delta = mod_bit ? 24'h000001 : 24'hFFFFFF;
      sum   = q.acc + delta;
      fsum  = q.facc + delta;
      flast = 11'((({1'b0, q.decim_field} + 12'h001) >> 3) - 12'h001);
      rsh   = {q.rem[34:0], q.num[34]};
      fin   = 1'b0;
      d        = q;
      d.irq    = 1'b0;
      d.rvalid = 1'b0;
      d.fvalid = 1'b0;

      // apb: read data latched in setup, ready in the access cycle
      d.pready  = psel && !penable;
      d.pslverr = 1'b0;
      if (psel && !penable) begin
         unique case (paddr)
            sdadc_pkg::OFS_CONTROL:  d.prdata = {29'h0, q.gn};
            sdadc_pkg::OFS_CONFIG:   d.prdata = {31'h0, q.ref_ext};
            sdadc_pkg::OFS_MODE:     d.prdata = {22'h0, q.done, q.busy, q.en, 4'h0, q.sm};
            sdadc_pkg::OFS_BUFFER:   d.prdata = {28'h0, q.buff};
            sdadc_pkg::OFS_MODCLK:   d.prdata = {24'h0, q.mdiv};
            sdadc_pkg::OFS_DECIM_HI: d.prdata = {29'h0, q.decim_field[10:8]};
            sdadc_pkg::OFS_DECIM_LO: d.prdata = {24'h0, q.decim_field[7:0]};
            sdadc_pkg::OFS_OFFSET:   d.prdata = {8'h0, q.off};
            sdadc_pkg::OFS_GAIN:     d.prdata = {8'h0, q.gain};
            sdadc_pkg::OFS_RESULT:   d.prdata = {8'h0, q.res};
            sdadc_pkg::OFS_FAST:     d.prdata = {8'h0, q.fres};
            default: begin
               d.prdata  = 32'h0000_0000;
               d.pslverr = 1'b1;
            end
         endcase
      end

      if (wr) begin
         unique case (paddr)
            sdadc_pkg::OFS_CONTROL:  d.gn = pwdata[2:0];
            sdadc_pkg::OFS_CONFIG:   d.ref_ext = pwdata[sdadc_pkg::CFG_REF_BIT];
            sdadc_pkg::OFS_MODE: begin
               d.en = pwdata[sdadc_pkg::MODE_EN_BIT];
               if (!q.busy) begin
                  d.sm = pwdata[sdadc_pkg::MODE_SM_LSB +: 3];
               end
               if (pwdata[sdadc_pkg::MODE_DONE_BIT]) begin
                  d.done = 1'b0;
               end
            end
            sdadc_pkg::OFS_BUFFER:   d.buff = pwdata[3:0];
            sdadc_pkg::OFS_MODCLK:   d.mdiv = pwdata[7:0];
            sdadc_pkg::OFS_DECIM_HI: d.decim_field[10:8] = pwdata[2:0];
            sdadc_pkg::OFS_DECIM_LO: d.decim_field[7:0] = pwdata[7:0];
            sdadc_pkg::OFS_OFFSET:   d.off = pwdata[23:0];
            sdadc_pkg::OFS_GAIN:     d.gain = pwdata[23:0];
            default: begin
            end
         endcase
      end

      // two filters run side by side on each modulator sample
      if (q.en && cdiv.samp) begin
         if (q.cnt == q.decim_field) begin
            word     = 1'b1;
            d.acc    = 24'h000000;
            d.cnt    = 11'h000;
            d.res    = correct(sum, q.off, q.gain);
            d.rvalid = 1'b1;
         end else begin
            d.acc = sum;
            d.cnt = q.cnt + 11'h001;
         end
         if (q.fcnt == flast) begin
            d.facc   = 24'h000000;
            d.fcnt   = 11'h000;
            d.fres   = correct(fsum, q.off, q.gain);
            d.fvalid = 1'b1;
         end else begin
            d.facc = fsum;
            d.fcnt = q.fcnt + 11'h001;
         end
      end

      // calibration sequencer
      unique case (q.st)
         S_IDLE: begin
            if (q.en && is_cal(q.sm)) begin
               d.st      = S_MEAS;
               d.busy    = 1'b1;
               d.second  = q.sm == sdadc_pkg::SM_INT_FULL;
               d.is_gain = q.sm == sdadc_pkg::SM_INT_GAIN || q.sm == sdadc_pkg::SM_SYS_GAIN;
               d.is_int  = q.sm == sdadc_pkg::SM_INT_FULL || q.sm == sdadc_pkg::SM_INT_OFS ||
                           q.sm == sdadc_pkg::SM_INT_GAIN;
               d.short   = d.is_int && !d.is_gain;
               d.fs      = d.is_int && d.is_gain;
               // a partial word would skew the measurement
               d.acc     = 24'h000000;
               d.cnt     = 11'h000;
            end
         end
         S_MEAS: begin
            if (word && !q.is_gain) begin
               d.off = sum;
               if (q.second) begin
                  d.second  = 1'b0;
                  d.is_gain = 1'b1;
                  d.short   = 1'b0;
                  d.fs      = 1'b1;
               end else begin
                  fin = 1'b1;
               end
            end else if (word) begin
               // full scale of the accumulator is the ratio itself
               d.den  = 25'($signed({sum[23], sum}) - $signed({q.off[23], q.off}));
               d.num  = 35'({1'b0, q.decim_field} + 12'h001) << sdadc_pkg::FRAC_BITS;
               d.rem  = 36'h0;
               d.quo  = 35'h0;
               d.step = 6'h00;
               d.st   = S_DIV;
            end
         end
         S_DIV: begin
            if (q.den[24] || q.den == 25'h0) begin
               d.gain = 24'hFFFFFF; // no usable slope, clamp
               fin    = 1'b1;
            end else begin
               // restoring division, one quotient bit a cycle
               d.num = {q.num[33:0], 1'b0};
               if (rsh >= {11'h0, q.den}) begin
                  d.rem = rsh - {11'h0, q.den};
                  d.quo = {q.quo[33:0], 1'b1};
               end else begin
                  d.rem = rsh;
                  d.quo = {q.quo[33:0], 1'b0};
               end
               d.step = q.step + 6'h01;
               if (q.step == sdadc_pkg::DIV_LAST) begin
                  d.gain = (|d.quo[34:24]) ? 24'hFFFFFF : d.quo[23:0];
                  fin    = 1'b1;
               end
            end
         end
         default: begin
            d.st = S_IDLE;
         end
      endcase

      if (fin) begin
         d.st    = S_IDLE;
         d.sm    = sdadc_pkg::SM_IDLE;
         d.busy  = 1'b0;
         d.done  = 1'b1;
         d.irq   = 1'b1;
         d.short = 1'b0;
         d.fs    = 1'b0;
      end

      // shutdown keeps settings but drops mode and any calibration
      if (!d.en) begin
         d.sm    = sdadc_pkg::SM_IDLE;
         d.st    = S_IDLE;
         d.busy  = 1'b0;
         d.short = 1'b0;
         d.fs    = 1'b0;
         d.acc   = 24'h000000;
         d.facc  = 24'h000000;
         d.cnt   = 11'h000;
         d.fcnt  = 11'h000;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         q      <= '0;
         q.st   <= S_IDLE;
         q.gain <= sdadc_pkg::RST_GAIN;
         q.off  <= sdadc_pkg::RST_OFFSET;
         q.decim_field <= sdadc_pkg::RST_DECIM;
         q.mdiv <= sdadc_pkg::RST_MODCLK;
      end else begin
         q <= d;
      end
   end

   // ***************************************************************
   // outputs
   // ***************************************************************
   assign prdata        = q.prdata;
   assign pready        = q.pready;
   assign pslverr       = q.pslverr;
   assign adc_power_on  = q.en;
   assign ref_ext_sel   = q.ref_ext;
   assign amp_gain_sel  = q.gn;
   assign buf_pos_sel   = q.buff[sdadc_pkg::BUF_POS_LSB +: 2];
   assign buf_neg_sel   = q.buff[sdadc_pkg::BUF_NEG_LSB +: 2];
   assign in_short_analog_ground = q.short;
   assign in_fullscale  = q.fs;
   assign mod_clk_tick  = cdiv.tick;
   assign conv_irq      = q.irq;
   assign result_valid  = q.rvalid;
   assign fast_valid    = q.fvalid;

   // ***************************************************************
   // checks
   // ***************************************************************
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);

   function automatic logic result_valid_next();
      return q.en && cdiv.samp && q.cnt == q.decim_field;
   endfunction : result_valid_next

   logic [10:0] ns_q;
   logic        mode_wr;
   assign mode_wr = psel && penable && pready && pwrite && paddr == sdadc_pkg::OFS_MODE;
   always_ff @(posedge sys_clk) begin
      if (!rst_n || !q.en || (d.busy && !q.busy) || result_valid_next()) begin
         ns_q <= 11'h000;
      end else if (cdiv.samp) begin
         ns_q <= ns_q + 11'h001;
      end
   end

   property p_enable;
      mode_wr |=> adc_power_on == $past(pwdata[sdadc_pkg::MODE_EN_BIT]);
   endproperty
   a_enable: assert property (p_enable) else $error("power does not follow enable");
   property p_shutdown;
      // the write that powers up may load a mode in the same edge, so judge the current cycle;
      // one last divider tick may still leave in the first cycle after power drops
      !adc_power_on |-> q.sm == sdadc_pkg::SM_IDLE && !q.busy && !in_short_analog_ground &&
                        (!mod_clk_tick || $past(adc_power_on));
   endproperty
   a_shutdown: assert property (p_shutdown) else $error("activity while disabled");
   property p_ref;
      psel && penable && pready && pwrite && paddr == sdadc_pkg::OFS_CONFIG |=> ref_ext_sel == $past(pwdata[0]);
   endproperty
   a_ref: assert property (p_ref) else $error("reference select not applied");
   property p_word_spacing;
      result_valid_next() |-> ns_q == q.decim_field;
   endproperty
   a_word_spacing: assert property (p_word_spacing) else $error("word after wrong sample count");
   property p_busy;
      q.st != S_IDLE |-> q.busy;
   endproperty
   a_busy: assert property (p_busy) else $error("busy low during calibration");
   property p_finish;
      $fell(q.busy) && q.en |-> q.done && conv_irq && q.sm == sdadc_pkg::SM_IDLE;
   endproperty
   a_finish: assert property (p_finish) else $error("calibration end not flagged");
   property p_short;
      q.st == S_MEAS && q.is_int && !q.is_gain |-> in_short_analog_ground && !in_fullscale;
   endproperty
   a_short: assert property (p_short) else $error("inputs not grounded");
   property p_fullscale;
      q.st == S_MEAS && q.is_int && q.is_gain |-> in_fullscale && !in_short_analog_ground;
   endproperty
   a_fullscale: assert property (p_fullscale) else $error("full scale not applied");
   property p_mode_lock;
      q.busy && mode_wr && pwdata[sdadc_pkg::MODE_EN_BIT] |=> q.sm == $past(q.sm) || !q.busy;
   endproperty
   a_mode_lock: assert property (p_mode_lock) else $error("mode changed while busy");
   cov_cal_done: cover property ($rose(q.done));
   cov_full_cal: cover property ($rose(q.busy) && q.second);
   cov_word:     cover property (result_valid);
   cov_fast:     cover property (fast_valid);
endmodule : sdadc_ctrl

// file: verilog/sdadc_pkg.sv
// constants shared by the converter control block and its clock divider
package sdadc_pkg;
   // ***************************************************************
   // register byte offsets
   // ***************************************************************
   localparam logic [7:0]  OFS_CONTROL   = 8'h00;
   localparam logic [7:0]  OFS_CONFIG    = 8'h04;
   localparam logic [7:0]  OFS_MODE      = 8'h08;
   localparam logic [7:0]  OFS_BUFFER    = 8'h0C;
   localparam logic [7:0]  OFS_MODCLK    = 8'h10;
   localparam logic [7:0]  OFS_DECIM_HI  = 8'h14;
   localparam logic [7:0]  OFS_DECIM_LO  = 8'h18;
   localparam logic [7:0]  OFS_OFFSET    = 8'h1C;
   localparam logic [7:0]  OFS_GAIN      = 8'h20;
   localparam logic [7:0]  OFS_RESULT    = 8'h24;
   localparam logic [7:0]  OFS_FAST      = 8'h28;
   // ***************************************************************
   // field positions
   // ***************************************************************
   localparam int          MODE_SM_LSB   = 0;
   localparam int          MODE_EN_BIT   = 7;
   localparam int          MODE_BUSY_BIT = 8;
   localparam int          MODE_DONE_BIT = 9;
   localparam int          CFG_REF_BIT   = 0;
   localparam int          BUF_POS_LSB   = 0;
   localparam int          BUF_NEG_LSB   = 2;
   // ***************************************************************
   // reset values
   // ***************************************************************
   localparam logic [23:0] RST_GAIN      = 24'h800000;
   localparam logic [23:0] RST_OFFSET    = 24'h000000;
   localparam logic [10:0] RST_DECIM     = 11'h013;
   localparam logic [7:0]  RST_MODCLK    = 8'h09;
   // ***************************************************************
   // system mode codes and buffer codes
   // ***************************************************************
   localparam logic [2:0]  SM_IDLE       = 3'h0;
   localparam logic [2:0]  SM_INT_FULL   = 3'h3;
   localparam logic [2:0]  SM_INT_OFS    = 3'h4;
   localparam logic [2:0]  SM_INT_GAIN   = 3'h5;
   localparam logic [2:0]  SM_SYS_OFS    = 3'h6;
   localparam logic [2:0]  SM_SYS_GAIN   = 3'h7;
   localparam logic [1:0]  BUF_BYPASS    = 2'h0;
   localparam logic [1:0]  BUF_LOW       = 2'h1;
   localparam logic [1:0]  BUF_HIGH      = 2'h2;
   // ***************************************************************
   // timing and arithmetic
   // ***************************************************************
   localparam int          OVERSAMPLE    = 128;
   localparam int          FRAC_BITS     = 23;
   localparam logic [5:0]  DIV_LAST      = 6'h22;
endpackage : sdadc_pkg

// file: verilog/cdiv_if.sv
// link between the control block and the modulator clock divider
interface cdiv_if;
   logic       en;   // converter powered, clocks may run
   logic [7:0] div;  // modulator clock divisor minus one
   logic       tick; // one modulator clock period elapsed
   logic       samp; // one modulator sample taken
   modport ctrl (output en, output div, input tick, input samp);
   modport gen  (input en, input div, output tick, output samp);
endinterface : cdiv_if

// file: verilog/modclk_gen.sv
// modulator clock enable divider and oversampling counter
module modclk_gen (
   input wire logic sys_clk, // system clock
   input wire logic rst_n,   // synchronous reset, active low
   cdiv_if.gen      bus      // divisor in, ticks out
);
   typedef struct packed {
      logic [7:0] div_cnt;
      logic [6:0] os_cnt;
      logic       tick;
      logic       samp;
   } gen_state_t;

   gen_state_t q;
   gen_state_t d;

   always_comb begin
      d      = q;
      d.tick = 1'b0;
      d.samp = 1'b0;
      if (!bus.en) begin
         // shutdown: counters parked, no new enables raised
         d.div_cnt = 8'h00;
         d.os_cnt  = 7'h00;
      end else if (q.div_cnt == bus.div) begin
         d.div_cnt = 8'h00;
         d.tick    = 1'b1;
         d.os_cnt  = q.os_cnt + 7'h01;
         d.samp    = (q.os_cnt == 7'(sdadc_pkg::OVERSAMPLE - 1));
      end else begin
         d.div_cnt = q.div_cnt + 8'h01;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign bus.tick = q.tick;
   assign bus.samp = q.samp;

   // ***************************************************************
   // checks
   // ***************************************************************
   property p_samp_on_tick;
      @(posedge sys_clk) disable iff (!rst_n) q.samp |-> q.tick && q.os_cnt == 7'h00;
   endproperty
   a_samp_on_tick: assert property (p_samp_on_tick) else $error("sample without modulator tick");
   cov_samp: cover property (@(posedge sys_clk) disable iff (!rst_n) q.samp);
endmodule : modclk_gen

// file: dv/mod_model.sv
// behavioural modulator feeding the control block a bitstream
module mod_model (
   input  wire logic sys_clk,       // system clock
   input  wire logic rst_n,         // synchronous reset, active low
   input  wire logic mod_clk_tick,  // modulator clock enable
   input  wire logic in_short_analog_ground, // inputs on analog ground
   input  wire logic in_fullscale,  // inputs on full scale
   output logic      mod_bit        // bitstream to the filter
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [6:0] tick_cnt_q;
   logic       phase_q;
   // ****************
   // bit pattern
   // ****************
   // one new bit per 128 ticks, so each sample sees a fresh value
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         tick_cnt_q <= 7'h00;
         phase_q    <= 1'b0;
      end else if (mod_clk_tick) begin
         tick_cnt_q <= tick_cnt_q + 7'h01;
         if (tick_cnt_q == 7'h7F) phase_q <= ~phase_q;
      end
   end
   // ground reads as a negative offset, an open input as zero mean
   assign mod_bit = in_fullscale | (~in_short_analog_ground & phase_q);
endmodule : mod_model

// file: dv/tb_sigma_delta_adc_control_calibration.sv
// self-checking bench for the converter control block
module tb_sigma_delta_adc_control_calibration;
   timeunit 1ns;
   timeprecision 1ps;
   logic        sys_clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic        pready, pslverr, mod_bit, adc_power_on, ref_ext_sel, in_short_analog_ground, in_fullscale;
   logic        mod_clk_tick, conv_irq, result_valid, fast_valid, er;
   logic [2:0]  amp_gain_sel;
   logic [1:0]  buf_pos_sel, buf_neg_sel;
   int          bad_count = 0, total_checks = 0, n;
   always #20 sys_clk = ~sys_clk;
   sdadc_ctrl DUT (.sys_clk, .rst_n, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready,
      .pslverr, .mod_bit, .adc_power_on, .ref_ext_sel, .amp_gain_sel, .buf_pos_sel, .buf_neg_sel,
      .in_short_analog_ground, .in_fullscale, .mod_clk_tick, .conv_irq, .result_valid, .fast_valid);
   mod_model partner (.sys_clk, .rst_n, .mod_clk_tick, .in_short_analog_ground, .in_fullscale, .mod_bit);
   // ****************
   // shared tasks
   // ****************
   task automatic report_and_stop();
      if (bad_count == 0 && total_checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : report_and_stop
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   // apb master: request held until pready is seen high
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      psel   <= 1'b1;
      pwrite <= w;
      paddr  <= a;
      pwdata <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      for (n = 0; n < 20 && pready !== 1'b1; n++) @(posedge sys_clk);
      if (n == 20) begin
         bad_count++;
         report_and_stop();
      end
      rd = prdata;
      er = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask : wr
   task automatic rc(input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk(rd, exp);
   endtask : rc
   task automatic settle();
      repeat (2) @(negedge sys_clk);
   endtask : settle
   // a pulse of conv_irq (sel 0), result_valid (sel 1) or fast_valid (sel 2), bounded
   task automatic wait_pulse(input bit [1:0] sel);
      for (n = 0; n < 9000; n++) begin
         @(posedge sys_clk);
         if ((sel[1] ? fast_valid : sel[0] ? result_valid : conv_irq) === 1'b1) return;
      end
      bad_count++;
      report_and_stop();
   endtask : wait_pulse
   task automatic ticks(input logic [31:0] exp);
      int c;
      c = 0;
      repeat (8) @(posedge sys_clk);
      repeat (40) begin
         @(posedge sys_clk);
         if (mod_clk_tick === 1'b1) c++;
      end
      chk(32'(c), exp);
   endtask : ticks
   // ****************
   // scenarios
   // ****************
   task automatic t_reset();
      rc(sdadc_pkg::OFS_GAIN, 32'(sdadc_pkg::RST_GAIN));
      rc(sdadc_pkg::OFS_OFFSET, 32'(sdadc_pkg::RST_OFFSET));
      rc(sdadc_pkg::OFS_DECIM_LO, 32'(sdadc_pkg::RST_DECIM[7:0]));
      rc(sdadc_pkg::OFS_DECIM_HI, 32'(sdadc_pkg::RST_DECIM[10:8]));
      rc(sdadc_pkg::OFS_MODCLK, 32'(sdadc_pkg::RST_MODCLK));
      chk(32'(buf_pos_sel), 32'(sdadc_pkg::BUF_BYPASS));
      rc(8'h40, 32'h0);
      chk(32'(er), 32'h1);
   endtask : t_reset
   task automatic t_config();
      for (int g = 0; g < 8; g++) begin
         wr(sdadc_pkg::OFS_CONTROL, 32'(g));
         settle();
         chk(32'(amp_gain_sel), 32'(g));
      end
      for (int i = 0; i < 2; i++) begin
         wr(sdadc_pkg::OFS_CONFIG, 32'(i));
         wr(sdadc_pkg::OFS_BUFFER, i ? 32'h9 : 32'h6);
         settle();
         chk(32'(ref_ext_sel), 32'(i));
         chk(32'(buf_pos_sel), i ? 32'(sdadc_pkg::BUF_LOW) : 32'(sdadc_pkg::BUF_HIGH));
         chk(32'(buf_neg_sel), i ? 32'(sdadc_pkg::BUF_HIGH) : 32'(sdadc_pkg::BUF_LOW));
      end
   endtask : t_config
   task automatic t_clock();
      wr(sdadc_pkg::OFS_MODCLK, 32'h3);
      wr(sdadc_pkg::OFS_MODE, 32'h80);
      settle();
      chk(32'(adc_power_on), 32'h1);
      ticks(32'd10);
      wr(sdadc_pkg::OFS_MODE, 32'h0);
      settle();
      chk(32'(adc_power_on), 32'h0);
      ticks(32'd0);
      rc(sdadc_pkg::OFS_CONTROL, 32'h7);
      wr(sdadc_pkg::OFS_MODCLK, 32'h0);
   endtask : t_clock
   task automatic t_abort();
      wr(sdadc_pkg::OFS_MODE, 32'h84);
      wr(sdadc_pkg::OFS_MODE, 32'h87);
      rc(sdadc_pkg::OFS_MODE, 32'h184);
      chk(32'(in_short_analog_ground), 32'h1);
      wr(sdadc_pkg::OFS_MODE, 32'h0);
      rc(sdadc_pkg::OFS_MODE, 32'h0);
   endtask : t_abort
   task automatic t_cal(input logic [2:0] c, input logic [1:0] f, input logic [23:0] o, input logic [23:0] g);
      wr(sdadc_pkg::OFS_MODE, 32'h280 | 32'(c));
      rc(sdadc_pkg::OFS_MODE, 32'h180 | 32'(c));
      chk(32'({in_short_analog_ground, in_fullscale}), 32'(f));
      wait_pulse(1'b0);
      rc(sdadc_pkg::OFS_MODE, 32'h280);
      rc(sdadc_pkg::OFS_OFFSET, 32'(o));
      rc(sdadc_pkg::OFS_GAIN, 32'(g));
   endtask : t_cal
   // ratio 20 is the smallest legal one and keeps each word short
   task automatic t_word();
      wait_pulse(1'b1);
      wait_pulse(1'b1);
      chk(32'(n + 1), 32'((sdadc_pkg::RST_DECIM + 1) * sdadc_pkg::OVERSAMPLE));
      rc(sdadc_pkg::OFS_RESULT, 32'h00000A);
   endtask : t_word
   // ratio 24 is a multiple of 8, so each fast word spans three samples
   task automatic t_fast();
      wr(sdadc_pkg::OFS_DECIM_LO, 32'h17);
      wait_pulse(2'h2);
      wait_pulse(2'h2);
      chk(32'(n + 1), 32'(24 / 8 * sdadc_pkg::OVERSAMPLE));
   endtask : t_fast
   initial begin
      repeat (5) @(posedge sys_clk);
      rst_n <= 1'b1;
      t_reset();
      t_config();
      t_clock();
      t_abort();
      t_cal(sdadc_pkg::SM_INT_FULL, 2'b10, 24'hFFFFEC, 24'h400000);
      t_word();
      t_cal(sdadc_pkg::SM_SYS_OFS, 2'b00, 24'h000000, 24'h400000);
      t_cal(sdadc_pkg::SM_INT_GAIN, 2'b01, 24'h000000, 24'h800000);
      t_cal(sdadc_pkg::SM_SYS_GAIN, 2'b00, 24'h000000, 24'hFFFFFF);
      t_cal(sdadc_pkg::SM_INT_OFS, 2'b10, 24'hFFFFEC, 24'hFFFFFF);
      wr(sdadc_pkg::OFS_OFFSET, 32'hFF123456);
      rc(sdadc_pkg::OFS_OFFSET, 32'h123456);
      t_fast();
      report_and_stop();
   end
endmodule : tb_sigma_delta_adc_control_calibration
